// *** src/hub_cfg_pkg.sv ***
// package: offsets, field positions and codes of the function 0 header
package hub_cfg_pkg;
    localparam logic [7:0] vendor_code_offset = 8'h00;
    localparam logic [7:0] device_code_offset = 8'h02;
    localparam logic [7:0] command_control_offset = 8'h04;
    localparam logic [7:0] status_offset = 8'h06;
    localparam int signalled_system_error_bit = 8;
    localparam int parity_error_response_enable = 6;
    localparam int special_cycle_enable_bit = 3;
    localparam int bus_master_enable_bit = 2;
    localparam int memory_access_enable_bit = 1;
    localparam int io_access_enable_bit = 0;
    localparam int detected_integrity_error_flag = 15;
    localparam int master_data_integrity_error_flag = 8;
    localparam logic [15:0] command_fixed_value = 16'h0006;
    localparam logic [15:0] command_writable_mask = 16'h0040;
    localparam logic [15:0] status_clearable_mask = 16'h8100;
    // arbitrary neutral identity values
    localparam logic [15:0] vendor_code_default = 16'h1234;
    localparam logic [15:0] device_code_default = 16'h5678;
    localparam logic [15:0] read_unmapped_value = 16'h0000;
endpackage

// *** src/sticky_enable.sv ***
// sticky enable flop kept across warm reset, cleared only by cold reset
`timescale 1ns/1ns
module sticky_enable (
    input wire logic mclk_in,
    input wire logic cold_rst_n_in,
    input wire logic ce_in,
    input wire logic wr_in,
    input wire logic d_in,
    output logic q_out
);
    logic q_reg;
    logic q_next;

    always_comb begin
        q_next = q_reg;
        if (ce_in && wr_in) begin
            q_next = d_in;
        end
    end

    always_ff @(posedge mclk_in or negedge cold_rst_n_in) begin
        if (!cold_rst_n_in) begin
            q_reg <= 1'b0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q_out = q_reg;
endmodule

// *** src/hub_link_function0_config_header.sv ***
// configuration header of link function 0: identity, command and status
//
// How it works
// - vendor code at offset 0 is read-only; writes change nothing
// - device code at offset 2 is read-only; writes change nothing
// - command bit 8 always reads zero, no system error cycle
// - command bit 6 sticky enable gates master data integrity error recording
// - detected integrity error is recorded regardless of the enable
// - command bit 3 reads zero; legacy special cycles never forwarded
// - command bit 2 bus master enable reads one
// - command bit 1 memory access enable reads one
// - command bit 0 io access enable reads zero
// - master data flag sets only on outbound read parity with enable
`timescale 1ns/1ns
module hub_link_function0_config_header (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic cold_rst_n_in,
    input wire logic ce_in,
    input wire logic cfg_rd_in,
    input wire logic cfg_wr_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic [15:0] cfg_wdata_in,
    input wire logic link_parity_err_in,
    input wire logic outbound_rd_parity_err_in,
    output logic [15:0] cfg_rdata_out,
    output logic cfg_rvalid_out,
    output logic parity_error_response_enable_out
);
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic det_reg;
    logic det_next;
    logic mstr_reg;
    logic mstr_next;
    logic perr_en;
    logic en_wr;
    logic pen_reg;
    logic sts_wr;

    // sticky enable, only writable command bit
    assign en_wr = cfg_wr_in && (cfg_addr_in == hub_cfg_pkg::command_control_offset);

    sticky_enable u_en (
        .mclk_in(mclk_in),
        .cold_rst_n_in(cold_rst_n_in),
        .ce_in(ce_in),
        .wr_in(en_wr),
        .d_in(cfg_wdata_in[hub_cfg_pkg::parity_error_response_enable]),
        .q_out(perr_en)
    );

    function automatic logic [15:0] command_value(input logic en);
        logic [15:0] v;
        v = hub_cfg_pkg::command_fixed_value;
        v[hub_cfg_pkg::parity_error_response_enable] = en;
        return v;
    endfunction

    assign sts_wr = cfg_wr_in && (cfg_addr_in == hub_cfg_pkg::status_offset);

    always_comb begin
        det_next = det_reg;
        mstr_next = mstr_reg;
        if (sts_wr && cfg_wdata_in[hub_cfg_pkg::detected_integrity_error_flag]) begin
            det_next = 1'b0;
        end
        if (sts_wr && cfg_wdata_in[hub_cfg_pkg::master_data_integrity_error_flag]) begin
            mstr_next = 1'b0;
        end
        if (link_parity_err_in) begin
            det_next = 1'b1;
        end
        // gated by enable; set beats clear
        if (outbound_rd_parity_err_in && perr_en) begin
            mstr_next = 1'b1;
        end
    end

    always_comb begin
        rvalid_next = cfg_rd_in;
        rdata_next = hub_cfg_pkg::read_unmapped_value;
        if (cfg_rd_in) begin
            case (cfg_addr_in)
                hub_cfg_pkg::vendor_code_offset: begin
                    rdata_next = hub_cfg_pkg::vendor_code_default;
                end
                hub_cfg_pkg::device_code_offset: begin
                    rdata_next = hub_cfg_pkg::device_code_default;
                end
                hub_cfg_pkg::command_control_offset: begin
                    rdata_next = command_value(perr_en);
                end
                hub_cfg_pkg::status_offset: begin
                    rdata_next[hub_cfg_pkg::detected_integrity_error_flag] = det_reg;
                    rdata_next[hub_cfg_pkg::master_data_integrity_error_flag] = mstr_reg;
                end
                default: begin
                    rdata_next = hub_cfg_pkg::read_unmapped_value;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
            det_reg <= 1'b0;
            mstr_reg <= 1'b0;
            pen_reg <= 1'b0;
        end else if (ce_in) begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            det_reg <= det_next;
            mstr_reg <= mstr_next;
            pen_reg <= perr_en;
        end
    end

    assign cfg_rdata_out = rdata_reg;
    assign cfg_rvalid_out = rvalid_reg;
    assign parity_error_response_enable_out = pen_reg;

    property p_vendor_ro;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && cfg_rd_in && cfg_addr_in == hub_cfg_pkg::vendor_code_offset
        |=> cfg_rdata_out == hub_cfg_pkg::vendor_code_default;
    endproperty
    a_vendor_ro: assert property (p_vendor_ro) else $error("vendor code wrong");

    property p_device_ro;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && cfg_rd_in && cfg_addr_in == hub_cfg_pkg::device_code_offset
        |=> cfg_rdata_out == hub_cfg_pkg::device_code_default;
    endproperty
    a_device_ro: assert property (p_device_ro) else $error("device code wrong");

    property p_cmd_fixed;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && cfg_rd_in && cfg_addr_in == hub_cfg_pkg::command_control_offset
        |=> (cfg_rdata_out & ~hub_cfg_pkg::command_writable_mask)
            == hub_cfg_pkg::command_fixed_value;
    endproperty
    a_cmd_fixed: assert property (p_cmd_fixed) else $error("fixed bits wrong");

    property p_en_write;
        @(posedge mclk_in) disable iff (!rst_n_in || !cold_rst_n_in)
        ce_in && en_wr ##1 ce_in |=> parity_error_response_enable_out
            == $past(cfg_wdata_in[hub_cfg_pkg::parity_error_response_enable], 2);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable not stored");

    property p_det_set;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && link_parity_err_in |=> det_reg;
    endproperty
    a_det_set: assert property (p_det_set) else $error("parity not reported");

    property p_mstr_gate;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && !mstr_reg && !(outbound_rd_parity_err_in && perr_en)
        |=> !mstr_reg;
    endproperty
    a_mstr_gate: assert property (p_mstr_gate) else $error("flag set wrongly");

    property p_mstr_set;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && outbound_rd_parity_err_in && perr_en |=> mstr_reg;
    endproperty
    a_mstr_set: assert property (p_mstr_set) else $error("flag not set");

    property p_unmapped;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && cfg_rd_in && cfg_addr_in > hub_cfg_pkg::status_offset
        |=> cfg_rdata_out == hub_cfg_pkg::read_unmapped_value && cfg_rvalid_out;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");

    property p_rvalid_set;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && cfg_rd_in
        |=> cfg_rvalid_out;
    endproperty
    a_rvalid_set: assert property (p_rvalid_set) else $error("no read valid");

    property p_rvalid_clr;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && !cfg_rd_in
        |=> !cfg_rvalid_out;
    endproperty
    a_rvalid_clr: assert property (p_rvalid_clr) else $error("stray valid");

    property p_bit8;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && cfg_rd_in
            && cfg_addr_in == hub_cfg_pkg::command_control_offset
        |=> !cfg_rdata_out[hub_cfg_pkg::signalled_system_error_bit];
    endproperty
    a_bit8: assert property (p_bit8) else $error("bit 8 not zero");

    property p_bit3;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && cfg_rd_in
            && cfg_addr_in == hub_cfg_pkg::command_control_offset
        |=> !cfg_rdata_out[hub_cfg_pkg::special_cycle_enable_bit];
    endproperty
    a_bit3: assert property (p_bit3) else $error("bit 3 not zero");

    property p_bit2;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && cfg_rd_in
            && cfg_addr_in == hub_cfg_pkg::command_control_offset
        |=> cfg_rdata_out[hub_cfg_pkg::bus_master_enable_bit];
    endproperty
    a_bit2: assert property (p_bit2) else $error("bit 2 not one");

    property p_bit1;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && cfg_rd_in
            && cfg_addr_in == hub_cfg_pkg::command_control_offset
        |=> cfg_rdata_out[hub_cfg_pkg::memory_access_enable_bit];
    endproperty
    a_bit1: assert property (p_bit1) else $error("bit 1 not one");

    property p_bit0;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && cfg_rd_in
            && cfg_addr_in == hub_cfg_pkg::command_control_offset
        |=> !cfg_rdata_out[hub_cfg_pkg::io_access_enable_bit];
    endproperty
    a_bit0: assert property (p_bit0) else $error("bit 0 not zero");

    // cold reset moves the enable at once, so it disables this check too
    property p_en_bit;
        @(posedge mclk_in) disable iff (!rst_n_in || !cold_rst_n_in)
        ce_in && cfg_rd_in
            && cfg_addr_in == hub_cfg_pkg::command_control_offset
        |=> cfg_rdata_out[hub_cfg_pkg::parity_error_response_enable]
            == $past(perr_en);
    endproperty
    a_en_bit: assert property (p_en_bit) else $error("enable bit wrong");

    property p_reserved;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && cfg_rd_in
            && cfg_addr_in == hub_cfg_pkg::command_control_offset
        |=> (cfg_rdata_out & ~(hub_cfg_pkg::command_fixed_value
            | hub_cfg_pkg::command_writable_mask)) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved set");

    property p_status_rsvd;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && cfg_rd_in && cfg_addr_in == hub_cfg_pkg::status_offset
        |=> (cfg_rdata_out & ~hub_cfg_pkg::status_clearable_mask)
            == 16'h0000;
    endproperty
    a_status_rsvd: assert property (p_status_rsvd) else $error("status bits");

    property p_det_read;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && cfg_rd_in && cfg_addr_in == hub_cfg_pkg::status_offset
        |=> cfg_rdata_out[hub_cfg_pkg::detected_integrity_error_flag]
            == $past(det_reg);
    endproperty
    a_det_read: assert property (p_det_read) else $error("status read");

    property p_det_hold;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && det_reg && !sts_wr
        |=> det_reg;
    endproperty
    a_det_hold: assert property (p_det_hold) else $error("flag lost");

    // a clear that meets a fresh error loses, so only a quiet cycle clears
    property p_det_clear;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && sts_wr && !link_parity_err_in
            && cfg_wdata_in[hub_cfg_pkg::detected_integrity_error_flag]
        |=> !det_reg;
    endproperty
    a_det_clear: assert property (p_det_clear) else $error("no clear");

    property p_mstr_hold;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && mstr_reg && !sts_wr
        |=> mstr_reg;
    endproperty
    a_mstr_hold: assert property (p_mstr_hold) else $error("flag lost");

    property p_mstr_clear;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && sts_wr && !outbound_rd_parity_err_in
            && cfg_wdata_in[hub_cfg_pkg::master_data_integrity_error_flag]
        |=> !mstr_reg;
    endproperty
    a_mstr_clear: assert property (p_mstr_clear) else $error("no clear");

    property p_freeze;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !ce_in
        |=> $stable(cfg_rdata_out) && $stable(cfg_rvalid_out)
            && $stable(det_reg) && $stable(mstr_reg);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved");

    property p_pen_copy;
        @(posedge mclk_in) disable iff (!rst_n_in || !cold_rst_n_in)
        ce_in
        |=> parity_error_response_enable_out == $past(perr_en);
    endproperty
    a_pen_copy: assert property (p_pen_copy) else $error("copy stale");
endmodule

// *** verification/link_error_source.sv ***
// far-side model: error pulses to the hub across the link
`timescale 1ns/1ns
module link_error_source (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [1:0] inject_in,
    output logic link_parity_err_out,
    output logic outbound_rd_parity_err_out
);
    // registered so each pulse changes just after an edge
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_parity_err_out <= 1'b0;
            outbound_rd_parity_err_out <= 1'b0;
        end else begin
            link_parity_err_out <= inject_in[0];
            outbound_rd_parity_err_out <= inject_in[1];
        end
    end
endmodule

// *** verification/hub_link_function0_config_header_tb.sv ***
// self-checking bench for the function 0 configuration header
`timescale 1ns/1ns
module hub_link_function0_config_header_tb;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cold_rst_n_in = 1'b0;
    logic cfg_rd_in = 1'b0;
    logic cfg_wr_in = 1'b0;
    logic [7:0] cfg_addr_in = 8'h00;
    logic [15:0] cfg_wdata_in = 16'h0000;
    logic [1:0] inject = 2'b00;
    logic ce = 1'b1;
    logic link_err;
    logic out_err;
    logic rvalid;
    logic en_out;
    logic [15:0] rdata;
    logic [15:0] exp_q[$];
    int num_errors = 0;
    int compares = 0;
    always #4 mclk_in = ~mclk_in;
    link_error_source far (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .inject_in(inject), .link_parity_err_out(link_err),
        .outbound_rd_parity_err_out(out_err));
    hub_link_function0_config_header dut (.mclk_in(mclk_in),
        .rst_n_in(rst_n_in), .cold_rst_n_in(cold_rst_n_in), .ce_in(ce),
        .cfg_rd_in(cfg_rd_in), .cfg_wr_in(cfg_wr_in),
        .cfg_addr_in(cfg_addr_in), .cfg_wdata_in(cfg_wdata_in),
        .link_parity_err_in(link_err), .outbound_rd_parity_err_in(out_err),
        .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid),
        .parity_error_response_enable_out(en_out));
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic access(input logic wr, input logic [7:0] a,
        input logic [15:0] d);
        @(posedge mclk_in);
        cfg_rd_in <= ~wr;
        cfg_wr_in <= wr;
        cfg_addr_in <= a;
        cfg_wdata_in <= d;
        @(posedge mclk_in);
        cfg_rd_in <= 1'b0;
        cfg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        access(1'b0, a, 16'h0000);
    endtask
    task automatic fire(input logic [1:0] k);
        @(posedge mclk_in);
        inject <= k;
        @(posedge mclk_in);
        inject <= 2'b00;
        repeat (3) @(posedge mclk_in);
    endtask
    task automatic pulse_reset(input logic cold);
        @(posedge mclk_in);
        if (cold) cold_rst_n_in <= 1'b0;
        else rst_n_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        cold_rst_n_in <= 1'b1;
        rst_n_in <= 1'b1;
    endtask
    // read data is registered at the taking edge
    // sampled mid-cycle, away from the edge that launches the data
    always @(negedge mclk_in) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0) check("extra read", 16'h0000, 16'h0001);
            else check("read data", rdata, exp_q.pop_front());
        end
    end
    initial begin
        repeat (4000) @(posedge mclk_in);
        num_errors++;
        results();
    end
    initial begin
        void'($urandom(32'h56e5820d));
        repeat (2) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        cold_rst_n_in <= 1'b1;
        rd(8'h00, hub_cfg_pkg::vendor_code_default);
        rd(8'h02, hub_cfg_pkg::device_code_default);
        rd(8'h04, 16'h0006);
        rd(8'h06, 16'h0000);
        rd(8'h08, hub_cfg_pkg::read_unmapped_value);
        $display("test reset values done");
        access(1'b1, 8'h00, 16'($urandom()));
        access(1'b1, 8'h02, 16'($urandom()));
        access(1'b1, 8'h04, 16'($urandom()) | 16'h0040);
        rd(8'h00, hub_cfg_pkg::vendor_code_default);
        rd(8'h02, hub_cfg_pkg::device_code_default);
        rd(8'h04, 16'h0046);
        check("enable copy", {15'h0000, en_out}, 16'h0001);
        $display("test write protection done");
        fire(2'b11);
        rd(8'h06, 16'h8100);
        access(1'b1, 8'h06, 16'h8100);
        rd(8'h06, 16'h0000);
        access(1'b1, 8'h04, 16'h0000);
        fire(2'b11);
        rd(8'h06, 16'h8000);
        access(1'b1, 8'h06, 16'h8100);
        access(1'b1, 8'h04, 16'h0040);
        $display("test error recording done");
        ce <= 1'b0;
        access(1'b1, 8'h04, 16'h0000);
        fire(2'b01);
        ce <= 1'b1;
        rd(8'h04, 16'h0046);
        rd(8'h06, 16'h0000);
        $display("test clock enable done");
        pulse_reset(1'b0);
        rd(8'h04, 16'h0046);
        rd(8'h06, 16'h0000);
        pulse_reset(1'b1);
        rd(8'h04, 16'h0006);
        $display("test warm and cold reset done");
        repeat (3) @(posedge mclk_in);
        check("pending reads", 16'(exp_q.size()), 16'h0000);
        results();
    end
endmodule
